// ### hw/rbt_pkg.sv
// package: widths, reset values and carrier types for the 18-bit registered transceiver
package rbt_pkg;
    // ============================================================
    // widths and reset values
    // ============================================================
    localparam int RBT_DATA_W = 18;
    localparam logic [RBT_DATA_W-1:0] RBT_DATA_RST = 18'h00000;
    localparam logic RBT_OE_RST = 1'b0;
    localparam logic RBT_BUS_HOLD_DEF = 1'b1;

    // ============================================================
    // per-direction control pins, sampled on clk_sys_in
    // ============================================================
    typedef struct packed {
        logic output_enable;   // a_to_b: active high; b_to_a: active low
        logic latch_enable;
        logic clock;
    } rbt_dir_ctrl_s;
endpackage : rbt_pkg

// ### hw/rbt_transceiver.sv
// design: 18-bit registered bus transceiver, both directions, with optional bus-hold keepers
`timescale 1ns/1ps

module rbt_transceiver
    import rbt_pkg::*;
#(
    parameter int DATA_W = RBT_DATA_W,
    parameter logic BUS_HOLD = RBT_BUS_HOLD_DEF
)(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire rbt_dir_ctrl_s ab_ctrl_in,
    input wire rbt_dir_ctrl_s ba_ctrl_in,
    input wire logic [DATA_W-1:0] a_data_in,
    input wire logic a_driven_in,
    input wire logic [DATA_W-1:0] b_data_in,
    input wire logic b_driven_in,
    output logic [DATA_W-1:0] a_data_out,
    output logic a_oe_out,
    output logic [DATA_W-1:0] b_data_out,
    output logic b_oe_out
);
    // ============================================================
    // state
    // ============================================================
    logic [DATA_W-1:0] stor_ab_ff, nxt_stor_ab;
    logic [DATA_W-1:0] stor_ba_ff, nxt_stor_ba;
    logic [DATA_W-1:0] keep_a_ff, nxt_keep_a;
    logic [DATA_W-1:0] keep_b_ff, nxt_keep_b;
    logic clk_ab_prev_ff, nxt_clk_ab_prev;
    logic clk_ba_prev_ff, nxt_clk_ba_prev;
    logic oe_b_ff, nxt_oe_b;
    logic oe_a_ff, nxt_oe_a;
    logic [DATA_W-1:0] din_a;
    logic [DATA_W-1:0] din_b;
    logic rise_ab;
    logic rise_ba;

    // ============================================================
    // shared next-storage decision for one direction
    // ============================================================
    // transparent while latch enable high, else capture on rising clock, else hold
    function automatic logic [DATA_W-1:0] rbt_next_store(
        input logic le,
        input logic rise,
        input logic [DATA_W-1:0] din,
        input logic [DATA_W-1:0] cur
    );
        logic [DATA_W-1:0] res;
        res = cur;
        if (le)
        begin
            res = din;
        end
        else if (rise)
        begin
            res = din;
        end
        return res;
    endfunction : rbt_next_store

    // ============================================================
    // input side: bus-hold keepers and clock edge detection
    // ============================================================
    // a released input reads the keeper, never an unknown float
    always_comb
    begin
        din_a = (BUS_HOLD && !a_driven_in) ? keep_a_ff : a_data_in;
        din_b = (BUS_HOLD && !b_driven_in) ? keep_b_ff : b_data_in;
        nxt_keep_a = din_a;
        nxt_keep_b = din_b;
        // a clock already high when latch enable fell gives no edge, so data is kept
        rise_ab = ab_ctrl_in.clock && !clk_ab_prev_ff;
        rise_ba = ba_ctrl_in.clock && !clk_ba_prev_ff;
        nxt_clk_ab_prev = ab_ctrl_in.clock;
        nxt_clk_ba_prev = ba_ctrl_in.clock;
    end

    // ============================================================
    // data paths and output enables, independent per direction
    // ============================================================
    // one cycle of latency is the price of registered outputs
    always_comb
    begin
        nxt_stor_ab = rbt_next_store(ab_ctrl_in.latch_enable, rise_ab, din_a, stor_ab_ff);
        nxt_stor_ba = rbt_next_store(ba_ctrl_in.latch_enable, rise_ba, din_b, stor_ba_ff);
        nxt_oe_b = ab_ctrl_in.output_enable;
        nxt_oe_a = !ba_ctrl_in.output_enable;
    end

    // register everything; storage keeps its value regardless of output enable
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stor_ab_ff <= RBT_DATA_RST;
            stor_ba_ff <= RBT_DATA_RST;
            keep_a_ff <= RBT_DATA_RST;
            keep_b_ff <= RBT_DATA_RST;
            clk_ab_prev_ff <= 1'b0;
            clk_ba_prev_ff <= 1'b0;
            oe_b_ff <= RBT_OE_RST;
            oe_a_ff <= RBT_OE_RST;
        end
        else
        begin
            stor_ab_ff <= nxt_stor_ab;
            stor_ba_ff <= nxt_stor_ba;
            keep_a_ff <= nxt_keep_a;
            keep_b_ff <= nxt_keep_b;
            clk_ab_prev_ff <= nxt_clk_ab_prev;
            clk_ba_prev_ff <= nxt_clk_ba_prev;
            oe_b_ff <= nxt_oe_b;
            oe_a_ff <= nxt_oe_a;
        end
    end

    // ============================================================
    // outputs straight from flops
    // ============================================================
    assign b_data_out = stor_ab_ff;
    assign a_data_out = stor_ba_ff;
    assign b_oe_out = oe_b_ff;
    assign a_oe_out = oe_a_ff;

    // ============================================================
    // assertions
    // ============================================================
    // transparent a_to_b: next b equals this cycle's a
    AST_AB_TRANSPARENT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ab_ctrl_in.latch_enable |=> b_data_out == $past(din_a))
        else $error("b port did not follow a in transparent mode");

    // latched with no clock edge: b must not move
    AST_AB_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!ab_ctrl_in.latch_enable && !rise_ab) |=> $stable(b_data_out))
        else $error("b port changed while latched");

    // clock sampled low then high with latch closed captures a
    AST_AB_CAPTURE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!ab_ctrl_in.latch_enable && !ab_ctrl_in.clock ##1 !ab_ctrl_in.latch_enable && ab_ctrl_in.clock)
        |=> b_data_out == $past(din_a))
        else $error("rising a_to_b clock did not capture a");

    // dropping the a_to_b enable releases b one cycle later
    AST_B_ENABLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ab_ctrl_in.output_enable ##1 !ab_ctrl_in.output_enable |=> !b_oe_out && $past(b_oe_out))
        else $error("b enable does not track a_to_b output enable");

    // b_to_a capture mirrors the a_to_b edge case
    AST_BA_CAPTURE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!ba_ctrl_in.latch_enable && rise_ba) |=> a_data_out == $past(din_b))
        else $error("rising b_to_a clock did not capture b");

    // two transparent cycles in a row: a follows b each time
    AST_BA_TRANSPARENT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ba_ctrl_in.latch_enable[*2] |=> a_data_out == $past(din_b) && $past(a_data_out) == $past(din_b, 2))
        else $error("a port did not follow b in transparent mode");

    // inverted enable every cycle; the release edge still loads reset values, so it is skipped
    AST_A_ENABLE_LOW: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !rst_in |=> a_oe_out == !$past(ba_ctrl_in.output_enable))
        else $error("a enable is not the inverse of b_to_a output enable");

    // clock held high over two latched cycles gives no capture
    AST_CLOCK_HELD_HIGH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ab_ctrl_in.clock && !ab_ctrl_in.latch_enable ##1 ab_ctrl_in.clock && !ab_ctrl_in.latch_enable)
        |=> $stable(b_data_out))
        else $error("b changed with a_to_b clock held high");

    // a released input reads the level it had while driven
    AST_BUS_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (BUS_HOLD && a_driven_in ##1 !a_driven_in) |-> din_a == $past(a_data_in))
        else $error("released a input lost its last state");

    // full tracking of the b enable, rises as well as falls
    AST_B_ENABLE_TRACK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !rst_in |=> b_oe_out == $past(ab_ctrl_in.output_enable))
        else $error("b enable is not a copy of a_to_b output enable");

    // latched b_to_a path with no clock edge: a must not move
    AST_BA_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!ba_ctrl_in.latch_enable && !rise_ba) |=> $stable(a_data_out))
        else $error("a port changed while latched");

    // b_to_a clock held high over two latched cycles keeps a
    AST_BA_CLOCK_HELD_HIGH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ba_ctrl_in.clock && !ba_ctrl_in.latch_enable ##1 ba_ctrl_in.clock && !ba_ctrl_in.latch_enable)
        |=> $stable(a_data_out))
        else $error("a changed with b_to_a clock held high");

    // a released b input reads the level it had while driven
    AST_B_BUS_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (BUS_HOLD && b_driven_in ##1 !b_driven_in) |-> din_b == $past(b_data_in))
        else $error("released b input lost its last state");

    // keeper stays put for the whole release; the edge after reset is skipped as keepers restart at zero
    AST_A_KEEPER_STEADY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (BUS_HOLD && !a_driven_in && !$past(rst_in)) |-> din_a == $past(din_a))
        else $error("a keeper drifted during a release");

    // main scenarios the random traffic should reach
    COV_AB_CAPTURE: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        !ab_ctrl_in.latch_enable && rise_ab && ab_ctrl_in.output_enable);
    COV_BA_TRANSPARENT: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        ba_ctrl_in.latch_enable && !ba_ctrl_in.output_enable);
    COV_LATCH_FALL: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        ab_ctrl_in.latch_enable ##1 !ab_ctrl_in.latch_enable[*3]);
    COV_BUS_RELEASE: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        b_driven_in ##1 !b_driven_in[*2]);
    COV_HELD_HIGH_FALL: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        ab_ctrl_in.latch_enable && ab_ctrl_in.clock ##1 !ab_ctrl_in.latch_enable && ab_ctrl_in.clock);
endmodule : rbt_transceiver

// ### testbench/rbt_far_bus.sv
// far-side board logic sharing the A and B buses with the device
`timescale 1ns/1ps

module rbt_far_bus
    import rbt_pkg::*;
(
    input wire logic a_oe_in,
    input wire logic [RBT_DATA_W-1:0] a_dev_in,
    input wire logic b_oe_in,
    input wire logic [RBT_DATA_W-1:0] b_dev_in,
    input wire logic [RBT_DATA_W-1:0] a_val_in,
    input wire logic [RBT_DATA_W-1:0] b_val_in,
    input wire logic a_rel_in,
    input wire logic b_rel_in,
    output logic [RBT_DATA_W-1:0] a_out,
    output logic a_drv_out,
    output logic [RBT_DATA_W-1:0] b_out,
    output logic b_drv_out
);
    // ============================================================
    // wire resolution
    // ============================================================
    // drive only while the device is off; a floating bus shows junk
    always_comb
    begin
        a_drv_out = a_oe_in | ~a_rel_in;
        b_drv_out = b_oe_in | ~b_rel_in;
        a_out = a_oe_in ? a_dev_in : (a_rel_in ? ~a_val_in : a_val_in);
        b_out = b_oe_in ? b_dev_in : (b_rel_in ? ~b_val_in : b_val_in);
    end
endmodule : rbt_far_bus

// ### testbench/registered_bus_transceiver_18b_test.sv
// self-checking bench: random traffic against a reference model
`timescale 1ns/1ps

module registered_bus_transceiver_18b_test;
    import rbt_pkg::*;
    logic clk_sys_in, rst_in, ar, br, ad, bd, aoe, boe, maoe, mboe, pab, pba;
    rbt_dir_ctrl_s ab, ba;
    logic [RBT_DATA_W-1:0] av, bv, aw, bw, ao, bo, ma, mb, ka, kb, ia, ib;
    logic [RBT_DATA_W-1:0] rao, rbo, rma, rmb;
    logic [15:0] rnd;
    int err_count, check_count, cyc;

    // ============================================================
    // clock, design and far side
    // ============================================================
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    rbt_transceiver #(.DATA_W(RBT_DATA_W), .BUS_HOLD(1'b1)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .ab_ctrl_in(ab), .ba_ctrl_in(ba), .a_data_in(aw), .a_driven_in(ad), .b_data_in(bw),
        .b_driven_in(bd), .a_data_out(ao), .a_oe_out(aoe), .b_data_out(bo), .b_oe_out(boe));

    rbt_far_bus far (.a_oe_in(aoe), .a_dev_in(ao), .b_oe_in(boe), .b_dev_in(bo), .a_val_in(av),
        .b_val_in(bv), .a_rel_in(ar), .b_rel_in(br), .a_out(aw), .a_drv_out(ad), .b_out(bw), .b_drv_out(bd));

    // variant without keepers: a released input is taken as the bus shows it
    rbt_transceiver #(.DATA_W(RBT_DATA_W), .BUS_HOLD(1'b0)) dut_raw (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .ab_ctrl_in(ab), .ba_ctrl_in(ba), .a_data_in(aw), .a_driven_in(ad), .b_data_in(bw),
        .b_driven_in(bd), .a_data_out(rao), .a_oe_out(), .b_data_out(rbo), .b_oe_out());

    // ============================================================
    // reference model, one edge of latency like the design
    // ============================================================
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {ma, mb, rma, rmb, ka, kb, maoe, mboe, pab, pba} = '0;
        end
        else
        begin
            ia = ad ? aw : ka;
            ib = bd ? bw : kb;
            ka = ia;
            kb = ib;
            if (ab.latch_enable | (ab.clock & ~pab)) mb = ia;
            if (ba.latch_enable | (ba.clock & ~pba)) ma = ib;
            if (ab.latch_enable | (ab.clock & ~pab)) rmb = aw;
            if (ba.latch_enable | (ba.clock & ~pba)) rma = bw;
            mboe = ab.output_enable;
            maoe = ~ba.output_enable;
            pab = ab.clock;
            pba = ba.clock;
        end
    end

    // ============================================================
    // checks and report
    // ============================================================
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic chk_data(input string n, input logic [RBT_DATA_W-1:0] e, input logic [RBT_DATA_W-1:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_data

    task automatic chk_oe(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk_oe

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // outputs settle by the falling edge
    always @(negedge clk_sys_in)
        if (!rst_in)
        begin
            chk_data("b_data", mb, bo);
            chk_data("a_data", ma, ao);
            chk_oe("b_oe", mboe, boe);
            chk_oe("a_oe", maoe, aoe);
            chk_data("b_data_raw", rmb, rbo);
            chk_data("a_data_raw", rma, rao);
        end

    // hang guard, well above the planned run
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc >= 3000)
        begin
            err_count++;
            results();
        end
    end

    // ============================================================
    // stimulus: random controls, data and bus releases
    // ============================================================
    initial
    begin
        {ab, ba, av, bv, ar, br} = '0;
        rst_in = 1'b1;
        rnd = 16'h0053;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (2000)
        begin
            @(posedge clk_sys_in);
            rnd = lfsr(rnd);
            ab <= rnd[2:0];
            ba <= rnd[5:3];
            ar <= rnd[6] & rnd[7];
            br <= rnd[8] & rnd[9];
            rnd = lfsr(rnd);
            av <= {rnd, rnd[1:0]};
            rnd = lfsr(rnd);
            bv <= {rnd[15:0], rnd[3:2]};
        end
        results();
    end
endmodule : registered_bus_transceiver_18b_test
